//--- verilog/dual_clock_queue_map.svh
// Offsets, field sizes, reset values and counts for the dual-clock queue
`ifndef DUAL_CLOCK_QUEUE_MAP_SVH
`define DUAL_CLOCK_QUEUE_MAP_SVH

// Width of the almost-full and almost-empty level settings
`define MAP_LVL_W            14
// Width of the bank-select decode on each side
`define MAP_BANK_W           2
// Bank decode that a side answers to by default
`define MAP_BANK_DEFAULT     2'h0
// Default push and pop word width in bits
`define MAP_WIDTH_DEFAULT    32'h0000_0012
// Storage bits for the 9, 18 and 36 bit organisations
`define MAP_BITS_PARITY      32'h0000_2400
// Storage bits for the 1, 2 and 4 bit organisations
`define MAP_BITS_PLAIN       32'h0000_2000
// Occupancy at which the empty flag is true
`define MAP_EMPTY_LEVEL      32'h0000_0000
// Reset values of the four flags
`define MAP_RST_FULL         1'h0
`define MAP_RST_ALMOST_FULL  1'h0
`define MAP_RST_ALMOST_EMPTY 1'h1
`define MAP_RST_EMPTY        1'h1

`endif

//--- verilog/dual_clock_queue_pkg.sv
// Types shared by the dual-clock queue and its test bench
package dual_clock_queue_pkg;

    // Data output taken straight from the array or through an extra stage
    typedef enum logic [0:0]
    {
        unbuffered_output = 1'h0,
        buffered_output   = 1'h1
    } output_stage_select_t;

    // How reset reaches the pointers and flags
    typedef enum logic [0:0]
    {
        clear_async = 1'h0,
        clear_sync  = 1'h1
    } clear_style_t;

    // The four status flags, all active high
    typedef struct packed
    {
        logic full_flag;
        logic almost_full_flag;
        logic almost_empty_flag;
        logic empty_flag;
    } queue_flags_t;

endpackage

//--- verilog/split_port_ram.sv
// Split-port storage array: one write port, one registered read port
`timescale 1ns/1ps

module split_port_ram #(
    parameter int unsigned NW      = 9,     // Bits per array entry
    parameter int unsigned ENTRIES = 1024,  // Entries in the array
    parameter int unsigned AW      = 10,    // Entry address width
    parameter int unsigned WR      = 2,     // Entries per written word
    parameter int unsigned RR      = 2      // Entries per read word
) (
    input  wire logic             wr_clk_in,   // Push clock
    input  wire logic             wr_en_in,    // Store this cycle
    input  wire logic [AW-1:0]    wr_addr_in,  // First entry written
    input  wire logic [WR*NW-1:0] wr_data_in,  // Word, low slice first
    input  wire logic             rd_clk_in,   // Pop clock
    input  wire logic             rd_arst_in,  // Asynchronous clear
    input  wire logic             rd_srst_in,  // Synchronous clear
    input  wire logic             rd_en_in,    // Fetch this cycle
    input  wire logic [AW-1:0]    rd_addr_in,  // First entry read
    output logic      [RR*NW-1:0] rd_data_out  // Fetched word
);

    // Storage words; reset never touches them
    logic [NW-1:0] mem [ENTRIES];

    // Write port: each slice lands in consecutive entries
    always_ff @(posedge wr_clk_in)
    begin
        if (wr_en_in)
        begin
            for (int i = 0; i < WR; i++)
            begin
                mem[AW'(wr_addr_in + AW'(i))] <= wr_data_in[i*NW +: NW];
            end
        end
    end

    // Read port register; the only state that reset clears
    always_ff @(posedge rd_clk_in or posedge rd_arst_in)
    begin
        if (rd_arst_in || rd_srst_in)
        begin
            rd_data_out <= '0;
        end
        else if (rd_en_in)
        begin
            for (int i = 0; i < RR; i++)
            begin
                rd_data_out[i*NW +: NW] <= mem[AW'(rd_addr_in + AW'(i))];
            end
        end
    end

endmodule

//--- verilog/dual_clock_queue.sv
// Dual-clock queue over a split-port array with programmable flags
`timescale 1ns/1ps
`include "dual_clock_queue_map.svh"

// How it works
// - Stores happen only on push clock edges
// - Reset clears port registers, never stored words
// - Organisations from 8K by 1 to 256 by 36
// - Push and pop widths selectable, default 18
// - Optional output stage loaded only by pop strobe
// - Full, almost full, almost empty, empty flags
// - Full at depth minus one; 14-bit levels
// - Empty and almost empty high after reset
// - Almost levels are absolute occupancy positions
// - Empty flags on pop clock, full on push
// - Reset zeroes both counters and full flags, sets empty flags
// - Push stores, pop fetches at counter locations
// - Rewind returns read counter for retransmission
// - First word two pop cycles after strobe
// - Empty view gated in by pop strobe register
// - Internal read enable is strobe and not empty
// - First push after full costs extra cycle
// - Buffered output adds third cycle before data
// - Two-bit bank decode per side, default zero
// - Only matching bank decode stores or fetches
module dual_clock_queue #(
    parameter int unsigned PUSH_WIDTH = `MAP_WIDTH_DEFAULT, // Push word bits
    parameter int unsigned POP_WIDTH  = `MAP_WIDTH_DEFAULT, // Pop word bits
    parameter dual_clock_queue_pkg::output_stage_select_t OUTPUT_STAGE =
        dual_clock_queue_pkg::unbuffered_output,
    parameter dual_clock_queue_pkg::clear_style_t CLEAR_STYLE =
        dual_clock_queue_pkg::clear_async,
    parameter logic [`MAP_BANK_W-1:0] PUSH_BANK_MATCH = `MAP_BANK_DEFAULT,
    parameter logic [`MAP_BANK_W-1:0] POP_BANK_MATCH  = `MAP_BANK_DEFAULT
) (
    input  wire logic                     clk_in,                 // Push clock
    input  wire logic                     pop_clock_in,           // Pop clock
    input  wire logic                     sys_rst_in,             // Reset, high
    input  wire logic                     push_request_in,        // Push strobe
    input  wire logic [PUSH_WIDTH-1:0]    push_data_in,           // Push word
    input  wire logic [`MAP_BANK_W-1:0]   push_bank_select_in,    // Push bank
    input  wire logic [`MAP_LVL_W-1:0]    almost_full_level_in,   // In push words
    input  wire logic                     pop_strobe_in,          // Pop strobe
    input  wire logic [`MAP_BANK_W-1:0]   pop_bank_select_in,     // Pop bank
    input  wire logic                     pop_pointer_rewind_in,  // Rewind reads
    input  wire logic [`MAP_LVL_W-1:0]    almost_empty_level_in,  // In pop words
    output logic      [POP_WIDTH-1:0]     pop_data_out,           // Pop word
    output dual_clock_queue_pkg::queue_flags_t queue_flags_out    // Flags
);

    // Organisation derived from the two widths
    localparam int unsigned NW = (PUSH_WIDTH < POP_WIDTH) ? PUSH_WIDTH : POP_WIDTH;
    localparam int unsigned CAP = (NW % 9 == 0) ? `MAP_BITS_PARITY : `MAP_BITS_PLAIN;
    localparam int unsigned ENTRIES = CAP / NW;       // Narrow entries
    localparam int unsigned AW = $clog2(ENTRIES);     // Entry address bits
    localparam int unsigned PW = AW + 1;              // Counter bits, wrap bit
    localparam int unsigned WR = PUSH_WIDTH / NW;     // Entries per push
    localparam int unsigned RR = POP_WIDTH / NW;      // Entries per pop
    localparam int unsigned WSH = $clog2(WR);         // Push step shift
    localparam int unsigned RSH = $clog2(RR);         // Pop step shift
    localparam int unsigned PUSH_DEPTH = ENTRIES / WR; // Push words held
    localparam int unsigned LW = `MAP_LVL_W;           // Level width
    localparam logic [LW-1:0] FULL_LEVEL = LW'(PUSH_DEPTH - 1);
    localparam logic [LW-1:0] EMPTY_LEVEL = LW'(`MAP_EMPTY_LEVEL);

    // Binary counter to gray code
    function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray code back to binary
    function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--)
        begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i + 1]);
        end
        return b;
    endfunction

    // Keeps a level between empty and full
    function automatic logic [LW-1:0] clamp_level(input logic [LW-1:0] lvl);
        return (lvl > FULL_LEVEL) ? FULL_LEVEL : lvl;
    endfunction

    // Reset routing for both domains
    logic pop_rst_s1;    // Reset seen on pop clock, stage one
    logic pop_rst_s2;    // Stage two
    logic pop_rst_s3;    // Stage three
    logic pop_rst_held;  // Accepted reset level on pop clock
    logic push_arst;     // Asynchronous clear, push side
    logic push_srst;     // Synchronous clear, push side
    logic pop_arst;      // Asynchronous clear, pop side
    logic pop_srst;      // Synchronous clear, pop side
    logic push_rst;      // Any clear, push side
    logic pop_rst;       // Any clear, pop side

    assign push_arst = (CLEAR_STYLE == dual_clock_queue_pkg::clear_async) && sys_rst_in;
    assign push_srst = (CLEAR_STYLE == dual_clock_queue_pkg::clear_sync) && sys_rst_in;
    assign pop_arst  = push_arst;
    assign pop_srst  = (CLEAR_STYLE == dual_clock_queue_pkg::clear_sync) && pop_rst_held;
    assign push_rst  = push_arst || push_srst;
    assign pop_rst   = pop_arst || pop_srst;

    // Brings the reset level onto the pop clock for the synchronous style
    always_ff @(posedge pop_clock_in)
    begin
        pop_rst_s1 <= sys_rst_in;
        pop_rst_s2 <= pop_rst_s1;
        pop_rst_s3 <= pop_rst_s2;
        pop_rst_held <= (pop_rst_s2 == pop_rst_s3) ? pop_rst_s2 : pop_rst_held;
    end

    // Push side state
    logic [PW-1:0] wr_bin_reg;       // Write counter in entries
    logic [PW-1:0] wr_bin_next;      // Write counter after this edge
    logic [PW-1:0] wr_gray_reg;      // Write counter, gray, push steps
    logic [PW-1:0] rd_gray_src;      // Read counter in pop steps
    logic [PW-1:0] rd_gray_s1;       // Read counter seen, stage one
    logic [PW-1:0] rd_gray_s2;       // Stage two
    logic [PW-1:0] rd_gray_s3;       // Stage three
    logic [PW-1:0] rd_seen_reg;      // Accepted read counter, gray
    logic [PW-1:0] rd_bin_seen;      // Accepted read counter, entries
    logic [PW-1:0] push_words;       // Push words held now
    logic [PW-1:0] push_words_next;  // Push words held after this edge
    logic          push_bank_hit;    // Push decode matches this block
    logic          full_reg;         // Full flag
    logic          almost_full_reg;  // Almost-full flag
    logic          full_gate_reg;    // Full as seen by the last push
    logic          wr_en;            // Internal store enable
    logic [LW-1:0] af_level;         // Clamped almost-full level

    assign push_bank_hit = (push_bank_select_in == PUSH_BANK_MATCH);
    assign wr_en = push_request_in && push_bank_hit && !full_reg && !full_gate_reg;
    assign wr_bin_next = wr_en ? PW'(wr_bin_reg + PW'(WR)) : wr_bin_reg;
    assign rd_bin_seen = from_gray(rd_seen_reg) << RSH;
    assign push_words = PW'(wr_bin_reg - rd_bin_seen) >> WSH;
    assign push_words_next = PW'(wr_bin_next - rd_bin_seen) >> WSH;
    assign af_level = clamp_level(almost_full_level_in);

    // Write counter; advances one push word per accepted store
    always_ff @(posedge clk_in or posedge push_arst)
    begin
        if (push_arst || push_srst)
        begin
            wr_bin_reg  <= '0;
            wr_gray_reg <= '0;
        end
        else
        begin
            wr_bin_reg  <= wr_bin_next;
            wr_gray_reg <= to_gray(wr_bin_next >> WSH);
        end
    end

    // Read counter crossing into the push clock
    always_ff @(posedge clk_in or posedge push_arst)
    begin
        if (push_arst || push_srst)
        begin
            rd_gray_s1  <= '0;
            rd_gray_s2  <= '0;
            rd_gray_s3  <= '0;
            rd_seen_reg <= '0;
        end
        else
        begin
            rd_gray_s1 <= to_gray(rd_gray_src);
            rd_gray_s2 <= rd_gray_s1;
            rd_gray_s3 <= rd_gray_s2;
            // Accept only once two stages agree
            rd_seen_reg <= (rd_gray_s2 == rd_gray_s3) ? rd_gray_s2 : rd_seen_reg;
        end
    end

    // Full flags, registered on the push clock
    always_ff @(posedge clk_in or posedge push_arst)
    begin
        if (push_arst || push_srst)
        begin
            full_reg        <= `MAP_RST_FULL;
            almost_full_reg <= `MAP_RST_ALMOST_FULL;
            full_gate_reg   <= `MAP_RST_FULL;
        end
        else
        begin
            full_reg        <= LW'(push_words_next) >= FULL_LEVEL;
            almost_full_reg <= LW'(push_words_next) >= af_level;
            // Full view refreshed only by a push strobe
            if (push_request_in)
            begin
                full_gate_reg <= full_reg;
            end
        end
    end

    // Pop side state
    logic [PW-1:0] rd_bin_reg;        // Read counter in entries
    logic [PW-1:0] rd_bin_next;       // Read counter after this edge
    logic [PW-1:0] wr_gray_s1;        // Write counter seen, stage one
    logic [PW-1:0] wr_gray_s2;        // Stage two
    logic [PW-1:0] wr_gray_s3;        // Stage three
    logic [PW-1:0] wr_seen_reg;       // Accepted write counter, gray
    logic [PW-1:0] wr_bin_seen;       // Accepted write counter, entries
    logic [PW-1:0] pop_words;         // Pop words held now
    logic [PW-1:0] pop_words_next;    // Pop words held after this edge
    logic          pop_bank_hit;      // Pop decode matches this block
    logic          empty_reg;         // Empty flag
    logic          almost_empty_reg;  // Almost-empty flag
    logic          empty_gate_reg;    // Empty as passed by the pop strobe
    logic          rd_en;             // Internal fetch enable
    logic [LW-1:0] ae_level;          // Clamped almost-empty level
    logic [RR*NW-1:0] ram_q;          // Word from the array

    assign pop_bank_hit = (pop_bank_select_in == POP_BANK_MATCH);
    assign rd_en = pop_strobe_in && pop_bank_hit && !empty_reg && !empty_gate_reg;
    assign rd_bin_next = pop_pointer_rewind_in ? '0 :
                         (rd_en ? PW'(rd_bin_reg + PW'(RR)) : rd_bin_reg);
    assign rd_gray_src = rd_bin_reg >> RSH;
    assign wr_bin_seen = from_gray(wr_seen_reg) << WSH;
    assign pop_words = PW'(wr_bin_seen - rd_bin_reg) >> RSH;
    assign pop_words_next = PW'(wr_bin_seen - rd_bin_next) >> RSH;
    assign ae_level = clamp_level(almost_empty_level_in);

    // Read counter; rewind wins over a fetch in the same cycle
    always_ff @(posedge pop_clock_in or posedge pop_arst)
    begin
        if (pop_arst || pop_srst)
        begin
            rd_bin_reg <= '0;
        end
        else
        begin
            rd_bin_reg <= rd_bin_next;
        end
    end

    // Write counter crossing into the pop clock
    always_ff @(posedge pop_clock_in or posedge pop_arst)
    begin
        if (pop_arst || pop_srst)
        begin
            wr_gray_s1  <= '0;
            wr_gray_s2  <= '0;
            wr_gray_s3  <= '0;
            wr_seen_reg <= '0;
        end
        else
        begin
            wr_gray_s1 <= wr_gray_reg;
            wr_gray_s2 <= wr_gray_s1;
            wr_gray_s3 <= wr_gray_s2;
            // Accept only once two stages agree
            wr_seen_reg <= (wr_gray_s2 == wr_gray_s3) ? wr_gray_s2 : wr_seen_reg;
        end
    end

    // Empty flags, registered on the pop clock
    always_ff @(posedge pop_clock_in or posedge pop_arst)
    begin
        if (pop_arst || pop_srst)
        begin
            empty_reg        <= `MAP_RST_EMPTY;
            almost_empty_reg <= `MAP_RST_ALMOST_EMPTY;
            empty_gate_reg   <= `MAP_RST_EMPTY;
        end
        else
        begin
            empty_reg        <= LW'(pop_words_next) == EMPTY_LEVEL;
            almost_empty_reg <= LW'(pop_words_next) <= ae_level;
            // Empty view passed on only by a pop strobe
            if (pop_strobe_in)
            begin
                empty_gate_reg <= empty_reg;
            end
        end
    end

    // Storage array
    split_port_ram #(
        .NW      (NW),
        .ENTRIES (ENTRIES),
        .AW      (AW),
        .WR      (WR),
        .RR      (RR)
    ) u_ram (
        .wr_clk_in   (clk_in),
        .wr_en_in    (wr_en),
        .wr_addr_in  (wr_bin_reg[AW-1:0]),
        .wr_data_in  (push_data_in),
        .rd_clk_in   (pop_clock_in),
        .rd_arst_in  (pop_arst),
        .rd_srst_in  (pop_srst),
        .rd_en_in    (rd_en),
        .rd_addr_in  (rd_bin_reg[AW-1:0]),
        .rd_data_out (ram_q)
    );

    // Output stage selection
    generate
        if (OUTPUT_STAGE == dual_clock_queue_pkg::buffered_output)
        begin : g_buffered
            logic [POP_WIDTH-1:0] out_reg; // Extra output stage

            // Loaded only by the pop strobe
            always_ff @(posedge pop_clock_in or posedge pop_arst)
            begin
                if (pop_arst || pop_srst)
                begin
                    out_reg <= '0;
                end
                else if (pop_strobe_in)
                begin
                    out_reg <= ram_q;
                end
            end
            assign pop_data_out = out_reg;

            AST_OUT_HOLD: assert property (@(posedge pop_clock_in) disable iff (pop_rst)
                !pop_strobe_in |=> $stable(pop_data_out))
                else $error("Output stage changed without a pop strobe");
        end
        else
        begin : g_unbuffered
            assign pop_data_out = ram_q;
        end
    endgenerate

    // Flag outputs
    assign queue_flags_out.full_flag         = full_reg;
    assign queue_flags_out.almost_full_flag  = almost_full_reg;
    assign queue_flags_out.almost_empty_flag = almost_empty_reg;
    assign queue_flags_out.empty_flag        = empty_reg;

    // Checks on the push side
    sequence s_push_refused;
        push_request_in && (full_reg || !push_bank_hit);
    endsequence

    AST_PUSH_BLOCKED: assert property (@(posedge clk_in) disable iff (push_rst)
        s_push_refused |=> $stable(wr_bin_reg))
        else $error("Refused push moved the write counter");

    AST_PUSH_BANK: assert property (@(posedge clk_in) disable iff (push_rst)
        wr_en |-> push_bank_select_in == PUSH_BANK_MATCH)
        else $error("Store with a foreign bank decode");

    AST_PUSH_RESET: assert property (@(posedge clk_in) disable iff (push_rst)
        $fell(push_rst) |-> (wr_bin_reg == '0) && !full_reg && !almost_full_reg)
        else $error("Push side not cleared by reset");

    AST_FULL_LEVEL: assert property (@(posedge clk_in) disable iff (push_rst)
        (LW'(push_words) >= FULL_LEVEL) |-> full_reg)
        else $error("Full flag low at the full level");

    AST_ALMOST_FULL: assert property (@(posedge clk_in) disable iff (push_rst)
        $stable(almost_full_level_in) && (LW'(push_words) >= af_level)
        |-> almost_full_reg)
        else $error("Almost-full flag low at its level");

    // Checks on the pop side
    sequence s_first_strobe;
        pop_strobe_in && pop_bank_hit && empty_gate_reg && !empty_reg;
    endsequence

    sequence s_second_strobe;
        pop_strobe_in && pop_bank_hit;
    endsequence

    AST_FIRST_READ: assert property (@(posedge pop_clock_in) disable iff (pop_rst)
        s_first_strobe ##1 s_second_strobe |-> rd_en)
        else $error("First fetch not on the second strobe");

    AST_READ_NEEDS_DATA: assert property (@(posedge pop_clock_in) disable iff (pop_rst)
        rd_en |-> (pop_words != '0) && !empty_gate_reg)
        else $error("Fetch while the queue is empty");

    AST_POP_RESET: assert property (@(posedge pop_clock_in) disable iff (pop_rst)
        $fell(pop_rst) |-> empty_reg && almost_empty_reg && (rd_bin_reg == '0))
        else $error("Empty flags not high after reset");

    AST_ALMOST_EMPTY: assert property (@(posedge pop_clock_in) disable iff (pop_rst)
        $stable(almost_empty_level_in) && !almost_empty_reg
        |-> LW'(pop_words) > ae_level)
        else $error("Almost-empty flag low at or below its level");

endmodule

//--- tb/queue_user_model.sv
// Pop-side user logic model for the dual-clock queue
`timescale 1ns/1ps

module queue_user_model (
    input  wire logic clk_in,         // Pop clock
    input  wire logic sys_rst_in,     // Reset, high
    input  wire logic enable_in,      // Popping allowed
    input  wire logic stall_in,       // Random hold-off, slow answers
    output logic      pop_strobe_out  // Pop strobe
);
    // Strobe moves just after an edge; a level while popping
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pop_strobe_out <= 1'h0;
        end
        else
        begin
            pop_strobe_out <= enable_in & ~stall_in;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the dual-clock queue
`timescale 1ns/1ps

module tb_top;
    logic        clk_in;              // Shared push and pop clock
    logic        sys_rst_in;          // Reset, high
    logic        push_request_in;     // Push strobe
    logic [17:0] push_data_in;        // Push word
    logic [1:0]  push_bank_select_in; // Push bank
    logic        enable;              // Partner may pop
    logic        stall;               // Partner hold-off
    logic        pop_strobe;          // Partner strobe
    logic [17:0] pop_data_out;        // Pop word
    logic [17:0] last;                // Last pop word seen
    logic [17:0] exp_q[$];            // Words still expected
    logic [8:0]  idx;                 // Word sequence number
    logic        after_full;          // Full seen on last attempt
    int          seed = 12;           // Random seed
    int          mismatches = 0;      // Failed compares
    int          compares = 0;        // All compares
    dual_clock_queue_pkg::queue_flags_t queue_flags_out; // Flags

    // Levels ordered 0 < 4 < 500 < 511
    dual_clock_queue i_dual_clock_queue (
        .clk_in(clk_in), .pop_clock_in(clk_in), .sys_rst_in(sys_rst_in),
        .push_request_in(push_request_in), .push_data_in(push_data_in),
        .push_bank_select_in(push_bank_select_in),
        .almost_full_level_in(14'h01F4),
        .pop_strobe_in(pop_strobe), .pop_bank_select_in(2'h0),
        .pop_pointer_rewind_in(1'h0), .almost_empty_level_in(14'h0004),
        .pop_data_out(pop_data_out), .queue_flags_out(queue_flags_out));

    queue_user_model i_queue_user_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .enable_in(enable), .stall_in(stall), .pop_strobe_out(pop_strobe));

    // Clock, 8 ns
    initial
    begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end

    // Random stalls for the partner
    always @(posedge clk_in) stall <= $random(seed);

    // Each new pop word must be the oldest one pushed
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
            last <= pop_data_out;
        else if (pop_data_out !== last)
        begin
            last <= pop_data_out;
            check(pop_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 18'h3_FFFF);
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One push, then idle cycles; acceptance from settled flags
    task automatic push(input logic [1:0] bank, input int gap);
        logic [17:0] d;
        @(negedge clk_in);
        idx = idx + 9'h001;
        d = {9'($random(seed)), idx};
        if (bank === 2'h0 && queue_flags_out.full_flag === 1'h0 && !after_full)
            exp_q.push_back(d);
        after_full = queue_flags_out.full_flag === 1'h1;
        @(posedge clk_in);
        push_request_in <= 1'h1;
        push_data_in <= d;
        push_bank_select_in <= bank;
        @(posedge clk_in);
        push_request_in <= 1'h0;
        repeat (gap) @(posedge clk_in);
    endtask

    // Reset for 10 cycles, flags checked meanwhile
    task automatic do_reset();
        sys_rst_in <= 1'h1;
        repeat (10) @(posedge clk_in);
        check(queue_flags_out, 4'h3);
        exp_q.delete();
        after_full = 1'h0;
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
    endtask

    // Partner pops until every word is out
    task automatic drain();
        int n;
        n = 0;
        enable <= 1'h1;
        while (exp_q.size() > 0 && n < 3000)
        begin
            @(posedge clk_in);
            n++;
        end
        repeat (12) @(posedge clk_in);
        check(exp_q.size(), 0);
        check(queue_flags_out, 4'h3);
        enable <= 1'h0;
        @(posedge clk_in);
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        sys_rst_in = 1'h1;
        push_request_in = 1'h0;
        push_data_in = 18'h0_0000;
        push_bank_select_in = 2'h0;
        enable = 1'h0;
        idx = 9'h000;
        after_full = 1'h0;
        do_reset();
        push(2'h1, 8);
        check(queue_flags_out, 4'h3);
        for (int i = 0; i < 60; i++) push(2'h0, 1 + ($random(seed) & 3));
        drain();
        for (int i = 0; i < 3; i++) push(2'h0, 1);
        do_reset();
        for (int i = 1; i <= 512; i++)
        begin
            push(2'h0, 1);
            @(negedge clk_in);
            if (i == 499) check(queue_flags_out, 4'h0);
            if (i == 500) check(queue_flags_out, 4'h4);
            if (i >= 511) check(queue_flags_out, 4'hC);
        end
        check(exp_q.size(), 511);
        drain();
        push(2'h0, 1);
        push(2'h0, 1);
        drain();
        end_of_test();
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        end_of_test();
    end
endmodule
